// ==== rtl/link_defs.vh ====
// Purpose: Constants for the word link format converter.
// Assumes: 20 MHz clock, 50 ns period.
// Notes:   Times are in nanoseconds; cycle counts derive from them.
`ifndef LINK_DEFS_VH
`define LINK_DEFS_VH
`define CLK_PERIOD_NS      50
`define SWAP_DELAY_NS      4000
`define SWAP_DELAY_CYC     (`SWAP_DELAY_NS / `CLK_PERIOD_NS)
`define WORD_PERIOD_NS     8000
`define HALF_W             12
`define WORD_W             24
`define FLAG_W             6
`define FN_SEL_W           6
`define FN_LINK_SEL        6'h09
`define FLAG_WC_FAULT_BIT  5
`define IN_FLAG_W          8
`define IN_PARITY_BIT      4
`define IN_WC_FAULT_BIT    6
`define IN_OPER_BIT        7
`endif

// ==== rtl/parity_gen.v ====
// Purpose: Even parity of a 12-bit half word.
// Assumes: Registered output, one cycle latency.
// Notes:   Shared by both directions of the converter.
`timescale 1ns/1ps
`default_nettype none
module parity_gen (
  // Clock and reset
  input  wire        clk,
  input  wire        srst,
  // Data
  input  wire [11:0] half,
  output reg         parity
);
  always @(posedge clk) begin
    if (srst) begin
      parity <= 1'b0;
    end else begin
      parity <= ^half;
    end
  end
endmodule // parity_gen
`default_nettype wire

// ==== rtl/link_control_unit.v ====
// Purpose: Converts 24-bit acquisition words to 12-bit host words and back, with parity.
// Assumes: One clock; acquisition and host strobes are pins and are synchronised.
// Notes:   Transfer pacing follows the acquisition side strobes.
// Operation
// RL1: Capture 24-bit word, send low half first.
// RL2: Swap halves after fixed delay, send upper.
// RL3: Compare combined parity, set parity error flag.
// RL4: Assemble two host halves, generate total parity.
// RL5: Acquisition side checks stored parity on read.
// RL6: Programmed flag handshake precedes block transfer.
// RL7: Words move one at a time, acquisition-paced.
// RL8: Word-count fault flag in and out.
// RL9: Even parity per word, both directions.
// RL10: Function word renews output flags, except operational.
// RL11: Timing signal holds off host status requests.
// RL12: Half sequencing cleared at each word start.
`timescale 1ns/1ps
`default_nettype none
`include "link_defs.vh"
module link_control_unit (
  // Clock and reset
  input  wire        clk,
  input  wire        srst,
  // Acquisition side parallel word channel
  input  wire [23:0] acq_out_word,
  input  wire        acq_out_parity,
  input  wire        acq_out_strobe,
  output reg  [23:0] acq_in_word,
  output reg         acq_in_parity,
  output reg         acq_in_ready,
  input  wire        acq_in_strobe,
  // Acquisition side flags
  input  wire        acq_system_timing,
  input  wire [6:0]  acq_flag_word,
  input  wire        acq_flag_load,
  output reg  [5:0]  out_flags,
  output reg         word_count_fault_out_flag,
  output reg         link_operational_out_flag,
  // Host channel adapter side
  output reg  [11:0] host_in_data,
  output reg         host_in_valid,
  input  wire [11:0] host_out_data,
  input  wire        host_out_strobe,
  input  wire [11:0] host_function,
  input  wire        host_function_strobe,
  input  wire        host_status_req,
  output reg  [7:0]  host_status,
  output reg         host_status_valid,
  // Manual switch and flags
  input  wire        link_switch,
  output reg         input_parity_error_flag,
  output reg         word_count_fault_in_flag
);
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_LOW   = 3'h1;
  localparam [2:0] ST_HIGH  = 3'h2;
  localparam [2:0] ST_CHECK = 3'h3;
  localparam [2:0] ST_ASM1  = 3'h4;
  localparam [2:0] ST_ASM2  = 3'h5;
  localparam [2:0] ST_SEND  = 3'h6;
  localparam [31:0] SWAP_CYC_FULL = `SWAP_DELAY_CYC;
  localparam [7:0]  SWAP_CYC      = SWAP_CYC_FULL[7:0];

  // Two-flop synchronisers for every pin input.
  reg  [7:0]  s1;
  reg  [7:0]  s2;
  reg  [7:0]  s3;
  wire [7:0]  pins = {link_switch, host_status_req, host_function_strobe, host_out_strobe,
                      acq_flag_load, acq_system_timing, acq_in_strobe, acq_out_strobe};
  always @(posedge clk) begin
    if (srst) begin
      s1 <= 8'h00;
      s2 <= 8'h00;
      s3 <= 8'h00;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
    end
  end
  wire rise_out  = s2[0] & ~s3[0];
  wire rise_in   = s2[1] & ~s3[1];
  wire sys_on    = s2[2];
  wire rise_flag = s2[3] & ~s3[3];
  wire rise_host = s2[4] & ~s3[4];
  wire rise_fn   = s2[5] & ~s3[5];
  wire stat_req  = s2[6];
  wire oper_sw   = s2[7];

  // Data pins pass the same two stages, so each word lines up with its strobe edge.
  reg  [55:0] d1;
  reg  [55:0] d2;
  wire [55:0] dpins = {acq_out_parity, acq_out_word, host_out_data, host_function, acq_flag_word};
  always @(posedge clk) begin
    if (srst) begin
      d1 <= 56'h00000000000000;
      d2 <= 56'h00000000000000;
    end else begin
      d1 <= dpins;
      d2 <= d1;
    end
  end
  wire [6:0]  flag_word_s = d2[6:0];
  wire [11:0] function_s  = d2[18:7];
  wire [11:0] host_data_s = d2[30:19];
  wire [23:0] acq_word_s  = d2[54:31];
  wire        acq_par_s   = d2[55];

  reg  [2:0]  state;
  reg  [23:0] word_reg;
  reg         rx_parity;
  reg         upper_parity;
  reg  [7:0]  delay_cnt;
  reg  [11:0] parity_src;
  wire        half_parity;

  parity_gen u_par (
    .clk    (clk),
    .srst   (srst),
    .half   (parity_src),
    .parity (half_parity)
  );

  // The upper position feeds the parity generator, except for the low half of a joined word.
  always @* begin
    parity_src = word_reg[23:12];
    if (state == ST_HIGH) begin
      parity_src = word_reg[23:12];
    end else if (state == ST_SEND) begin
      parity_src = word_reg[11:0];
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      state                   <= ST_IDLE;
      word_reg                <= 24'h000000;
      rx_parity               <= 1'b0;
      upper_parity            <= 1'b0;
      delay_cnt               <= 8'h00;
      host_in_data            <= 12'h000;
      host_in_valid           <= 1'b0;
      acq_in_word             <= 24'h000000;
      acq_in_parity           <= 1'b0;
      acq_in_ready            <= 1'b0;
      input_parity_error_flag <= 1'b0;
    end else begin
      host_in_valid <= 1'b0;
      // Flag renewal writes the parity error bit; a failed check in the same cycle overrides it below.
      if (rise_flag) begin
        input_parity_error_flag <= flag_word_s[`IN_PARITY_BIT]; // RL6
      end
      case (state)
        ST_IDLE: begin
          delay_cnt <= 8'h00; // RL12
          if (rise_out && out_flags[3]) begin
            word_reg  <= acq_word_s; // RL1
            rx_parity <= acq_par_s;
            state     <= ST_LOW;
          end else if (rise_host && out_flags[4]) begin
            word_reg[11:0] <= host_data_s; // RL4
            state          <= ST_ASM1;
          end
        end
        ST_LOW: begin
          host_in_data <= word_reg[11:0]; // RL1
          if (delay_cnt == 8'h00) begin
            host_in_valid <= 1'b1;
          end
          if (delay_cnt == 8'h02) begin
            upper_parity <= half_parity; // RL1
          end
          if (delay_cnt == SWAP_CYC - 8'h01) begin
            word_reg  <= {word_reg[11:0], word_reg[23:12]}; // RL2
            delay_cnt <= 8'h00;
            state     <= ST_HIGH;
          end else begin
            delay_cnt <= delay_cnt + 8'h01;
          end
        end
        ST_HIGH: begin
          host_in_data  <= word_reg[11:0]; // RL2
          host_in_valid <= (delay_cnt == 8'h00);
          delay_cnt     <= delay_cnt + 8'h01;
          if (delay_cnt == 8'h02) begin
            state <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          // Parity generator now holds the parity of the original low half.
          if ((upper_parity ^ half_parity) != rx_parity) begin
            input_parity_error_flag <= 1'b1; // RL3 RL9
          end
          state <= ST_IDLE; // RL7
        end
        ST_ASM1: begin
          if (rise_host) begin
            word_reg <= {host_data_s, word_reg[11:0]}; // RL4
            state    <= ST_ASM2;
          end
        end
        ST_ASM2: begin
          delay_cnt <= 8'h00;
          state     <= ST_SEND;
        end
        ST_SEND: begin
          delay_cnt <= delay_cnt + 8'h01;
          if (delay_cnt == 8'h00) begin
            upper_parity <= ^word_reg[23:12];
          end
          if (delay_cnt == 8'h02) begin
            acq_in_word   <= word_reg; // RL4
            acq_in_parity <= upper_parity ^ half_parity; // RL9
            acq_in_ready  <= 1'b1;
          end
          if (acq_in_ready && rise_in) begin
            acq_in_ready <= 1'b0; // RL7
            state        <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Output flags renewed by a host function word addressed to the link; the operational flag follows the switch instead.
  always @(posedge clk) begin
    if (srst) begin
      out_flags                 <= 6'h00;
      word_count_fault_out_flag <= 1'b0;
      link_operational_out_flag <= 1'b0;
    end else begin
      link_operational_out_flag <= oper_sw; // RL10
      if (rise_fn && function_s[11:6] == `FN_LINK_SEL) begin
        out_flags                 <= function_s[5:0]; // RL10 RL6
        word_count_fault_out_flag <= function_s[`FLAG_WC_FAULT_BIT]; // RL8
      end
    end
  end

  // Input flags from the acquisition side and status answers to the host.
  // The other input flags are held from the last renewal, not read live from the pins.
  reg  [4:0]  held_flags;
  always @(posedge clk) begin
    if (srst) begin
      word_count_fault_in_flag <= 1'b0;
      held_flags               <= 5'h00;
      host_status              <= 8'h00;
      host_status_valid        <= 1'b0;
    end else begin
      if (rise_flag) begin
        word_count_fault_in_flag <= flag_word_s[`IN_WC_FAULT_BIT]; // RL8 RL6
        held_flags               <= {flag_word_s[5], flag_word_s[3:0]}; // RL6
      end
      host_status_valid <= 1'b0;
      if (stat_req && !sys_on && !host_status_valid) begin
        host_status <= {oper_sw, word_count_fault_in_flag, held_flags[4],
                        input_parity_error_flag, held_flags[3:0]}; // RL11
        host_status_valid <= 1'b1;
      end
    end
  end
endmodule // link_control_unit
`default_nettype wire

// ==== tb/link_checker_asserts.sv ====
// Purpose: Assertions on the link control unit ports.
// Assumes: Pins pass a two-flop synchroniser.
// Notes:   Bound from the testbench file.
`timescale 1ns/1ps
`default_nettype none
module link_checker (
  input wire logic clk, srst, host_in_valid, host_status_valid, acq_system_timing, link_switch, acq_in_ready,
  input wire logic link_operational_out_flag, host_function_strobe, acq_in_strobe,
  input wire logic input_parity_error_flag, acq_flag_load, acq_in_parity,
  input wire logic [5:0]  out_flags,
  input wire logic [23:0] acq_in_word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  AST_HALF_GAP: assert property (host_in_valid |=> !host_in_valid [*8]) else $error("halves close");
  AST_STATUS_HOLD: assert property (acq_system_timing [*6] |-> !host_status_valid) else $error("status");
  AST_OPER: assert property (link_switch [*5] |-> link_operational_out_flag) else $error("oper");
  AST_FLAGS_KEEP: assert property (!host_function_strobe [*6] |-> $stable(out_flags)) else $error("flags");
  AST_PERR_STICKY: assert property (!acq_flag_load [*6] ##0 input_parity_error_flag |=> input_parity_error_flag)
    else $error("perr");
  AST_READY_HOLD: assert property (!acq_in_strobe [*6] ##0 acq_in_ready |=> acq_in_ready) else $error("ready");
  AST_WORD_HOLD: assert property (acq_in_ready ##1 acq_in_ready |-> $stable(acq_in_word)) else $error("word");
  AST_IN_PARITY: assert property (acq_in_ready |-> acq_in_parity == ^acq_in_word) else $error("parity");
  cover property (host_in_valid);
  cover property ($rose(input_parity_error_flag));
  cover property ($fell(acq_in_ready));
endmodule // link_checker
`default_nettype wire

// ==== tb/acq_side_model.sv ====
// Purpose: Acquisition side taking words from the link.
// Assumes: Ready stands until the acknowledge pin rises.
// Notes:   The bench sets the acknowledge latency.
`timescale 1ns/1ps
`default_nettype none
module acq_side_model (
  input wire logic        clk, acq_in_ready, acq_in_parity,
  input wire logic [23:0] acq_in_word,
  input wire logic [3:0]  ack_lat,
  output var logic        acq_in_strobe, got_bad,
  output var logic [23:0] got_word,
  output int              got_n
);
  initial begin
    acq_in_strobe = 0;
    got_n = 0;
  end
  always begin
    @(negedge clk);
    if (acq_in_ready === 1'b1) begin
      got_word = acq_in_word;
      got_bad = acq_in_parity != ^acq_in_word;
      got_n++;
      repeat (ack_lat) @(negedge clk);
      acq_in_strobe = 1;
      for (int i = 0; i < 9 && acq_in_ready; i++) @(negedge clk);
      acq_in_strobe = 0;
    end
  end
endmodule // acq_side_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the link control unit.
// Assumes: Inputs change on the falling edge.
// Notes:   Random words from a fixed seed.
`timescale 1ns/1ps
`default_nettype none
`include "link_defs.vh"
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin fail_count++; $display("ERROR %s exp %h seen %h", n, e, a); end end
`define WAITFOR(c) begin for (i = 0; i < 300 && !(c); i++) @(negedge clk); if (!(c)) begin fail_count++; report_and_stop(); end end
module testbench;
  logic clk = 0, srst = 1, acq_out_parity = 0, acq_out_strobe = 0, acq_system_timing = 0, acq_flag_load = 0;
  logic host_out_strobe = 0, host_function_strobe = 0, host_status_req = 0, link_switch = 0;
  logic [23:0] acq_out_word = 0, acq_in_word, got_word, w;
  logic [11:0] host_out_data = 0, host_function = 0, host_in_data;
  logic [6:0] acq_flag_word = 0;
  logic [5:0] out_flags;
  logic [7:0] host_status;
  logic [3:0] ack_lat = 0;
  logic acq_in_parity, acq_in_ready, acq_in_strobe, got_bad, host_in_valid, host_status_valid;
  logic word_count_fault_out_flag, link_operational_out_flag, input_parity_error_flag, word_count_fault_in_flag;
  int got_n, fail_count = 0, n_checks = 0, i, gap;
  always #25 clk = ~clk;
  link_control_unit u_link_control_unit (
    .clk                       (clk),
    .srst                      (srst),
    .acq_out_word              (acq_out_word),
    .acq_out_parity            (acq_out_parity),
    .acq_out_strobe            (acq_out_strobe),
    .acq_in_word               (acq_in_word),
    .acq_in_parity             (acq_in_parity),
    .acq_in_ready              (acq_in_ready),
    .acq_in_strobe             (acq_in_strobe),
    .acq_system_timing         (acq_system_timing),
    .acq_flag_word             (acq_flag_word),
    .acq_flag_load             (acq_flag_load),
    .out_flags                 (out_flags),
    .word_count_fault_out_flag (word_count_fault_out_flag),
    .link_operational_out_flag (link_operational_out_flag),
    .host_in_data              (host_in_data),
    .host_in_valid             (host_in_valid),
    .host_out_data             (host_out_data),
    .host_out_strobe           (host_out_strobe),
    .host_function             (host_function),
    .host_function_strobe      (host_function_strobe),
    .host_status_req           (host_status_req),
    .host_status               (host_status),
    .host_status_valid         (host_status_valid),
    .link_switch               (link_switch),
    .input_parity_error_flag   (input_parity_error_flag),
    .word_count_fault_in_flag  (word_count_fault_in_flag)
  );
  acq_side_model u_acq_side_model (
    .clk           (clk),
    .acq_in_ready  (acq_in_ready),
    .acq_in_parity (acq_in_parity),
    .acq_in_word   (acq_in_word),
    .ack_lat       (ack_lat),
    .acq_in_strobe (acq_in_strobe),
    .got_bad       (got_bad),
    .got_word      (got_word),
    .got_n         (got_n)
  );
  // Status word expected from the last renewed input flags and the switch set on.
  function automatic logic [7:0] exp_status(input logic [6:0] fw, input logic perr);
    return {1'b1, fw[6], fw[5], perr, fw[3:0]};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic func(input logic [5:0] f);
    host_function = {`FN_LINK_SEL, f};
    host_function_strobe = 1;
    repeat (3) @(negedge clk);
    host_function_strobe = 0;
    repeat (6) @(negedge clk);
    `CHK("flags", f, out_flags)
    `CHK("count out", f[5], word_count_fault_out_flag)
  endtask
  task automatic flags(input logic [6:0] v);
    acq_flag_word = v;
    acq_flag_load = 1;
    repeat (3) @(negedge clk);
    acq_flag_load = 0;
    repeat (6) @(negedge clk);
    `CHK("count in", v[6], word_count_fault_in_flag)
    `CHK("perr renew", v[4], input_parity_error_flag)
  endtask
  task automatic acq_word(input logic bad);
    w = 24'($urandom);
    acq_out_word = w;
    acq_out_parity = (^w) ^ bad;
    acq_out_strobe = 1;
    `WAITFOR(host_in_valid)
    `CHK("low half", w[11:0], host_in_data)
    @(negedge clk);
    acq_out_strobe = 0;
    for (gap = 1; gap < 200 && !host_in_valid; gap++) @(negedge clk);
    if (!host_in_valid) begin
      fail_count++;
      report_and_stop();
    end
    `CHK("gap", `SWAP_DELAY_CYC, gap)
    `CHK("high half", w[23:12], host_in_data)
    repeat (6) @(negedge clk);
    `CHK("perr", bad, input_parity_error_flag)
    $display("acq word done");
  endtask
  task automatic host_word();
    int n0;
    n0 = got_n;
    w = 24'($urandom);
    for (int k = 0; k < 2; k++) begin
      host_out_data = k ? w[23:12] : w[11:0];
      host_out_strobe = 1;
      repeat (3) @(negedge clk);
      host_out_strobe = 0;
      repeat (4) @(negedge clk);
    end
    `WAITFOR(got_n == n0 + 1)
    `CHK("joined", w, got_word)
    `CHK("total parity", 1'b0, got_bad)
    repeat (20) @(negedge clk);
    $display("host word done");
  endtask
  initial begin
    void'($urandom(2764));
    repeat (12) @(negedge clk);
    srst = 0;
    repeat (4) @(negedge clk);
    func(6'h38);
    link_switch = 1;
    func(6'h18);
    `CHK("oper", 1'b1, link_operational_out_flag)
    acq_word(1'b0);
    acq_word(1'b1);
    flags(7'h40);
    acq_word(1'b0);
    flags(7'h10);
    flags(7'h00);
    for (int r = 0; r < 4; r++) begin
      acq_word(1'b0);
      ack_lat = 4'($urandom_range(7));
      host_word();
    end
    acq_system_timing = 1;
    host_status_req = 1;
    repeat (20) @(negedge clk);
    `CHK("status held", 1'b0, host_status_valid)
    acq_system_timing = 0;
    `WAITFOR(host_status_valid)
    `CHK("status oper", 1'b1, host_status[`IN_OPER_BIT])
    `CHK("status word", exp_status(7'h00, 1'b0), host_status)
    host_status_req = 0;
    report_and_stop();
  end
endmodule // testbench
bind link_control_unit link_checker u_link_checker (
  .clk                       (clk),
  .srst                      (srst),
  .host_in_valid             (host_in_valid),
  .host_status_valid         (host_status_valid),
  .acq_system_timing         (acq_system_timing),
  .link_switch               (link_switch),
  .acq_in_ready              (acq_in_ready),
  .link_operational_out_flag (link_operational_out_flag),
  .host_function_strobe      (host_function_strobe),
  .acq_in_strobe             (acq_in_strobe),
  .input_parity_error_flag   (input_parity_error_flag),
  .acq_flag_load             (acq_flag_load),
  .acq_in_parity             (acq_in_parity),
  .out_flags                 (out_flags),
  .acq_in_word               (acq_in_word)
);
`default_nettype wire
